// ### logic/efp_core.sv
`timescale 1ns/1ps
// Contract
// - two sticky flag bytes at CE, CF; CD reads zero
// - alert when masked flag and legacy zero
// - alert low otherwise
// - flag reads never change flags
// - flag write ANDs written value in
// - host writes only clear flags
// - transmit done, after ack if wanted
// - receive waiting follows undelivered bytes
// - plaintext flag only when accepted
// - sequence decrease flag
// - sequence skip flag
// - join flag, reserved bits zero
// - low byte event bit assignments
// - option registers, upper bits zero
// - automatic mode triggers
// - explicit mode waits for send
// - packet holds bytes at trigger
// - packets queue, mode change flushes
// - command line fall acts as send
// - held receive waits for get command
// - streamed receive paced by hold setting
// - CTS status use option
module efp_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access from command decoder
  input wire efp_pkg::efp_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  // Internal events
  input wire efp_pkg::efp_event_type events,
  input wire logic rx_bytes_pending,
  input wire logic accept_plaintext_option,
  // Masks and trigger settings held elsewhere
  input wire logic [23:0] extended_event_mask,
  input wire logic [7:0] legacy_event_mask,
  input wire logic [7:0] byte_count_trigger,
  input wire logic [15:0] data_idle_timeout,
  input wire logic [7:0] slot_room,
  input wire logic command_hold_setting,
  // Host commands and command pin
  input wire efp_pkg::efp_cmd_type cmd,
  input wire logic cmd_line_n,
  // Outgoing byte stream
  input wire logic tx_byte_valid,
  output logic tx_byte_ready,
  // Outgoing packet descriptors
  output logic pkt_valid,
  input wire logic pkt_ready,
  output efp_pkg::efp_pkt_type pkt,
  output logic tx_flush,
  // Receive side
  input wire logic rx_xfer_done,
  output logic rx_xfer_active,
  output logic rx_stream_enable,
  output logic cts_status_drive,
  output logic cts_flow_enable,
  output logic command_response_line_status_drive,
  // Status
  output logic alert_status_line,
  output logic [3:0] packet_transfer_options
);
  import efp_pkg::*;

  typedef struct packed {
    logic [7:0] flags0;
    logic [FLAG1_W-1:0] flags1;
    logic [OPT_W-1:0] opt_vol;
    logic [OPT_W-1:0] opt_nv;
    logic [7:0] rdata;
    logic alert;
    logic [7:0] prev_seq;
    logic seq_seen;
    logic [7:0] pending;
    logic [15:0] idle;
    logic send_req;
    logic cmd_s1;
    logic cmd_s2;
    logic cmd_s3;
    logic rx_active;
  } efp_state_type;

  efp_state_type st;
  efp_state_type next_st;
  logic cmd_fall;
  logic send_now;
  logic tx_done_set;
  logic seq_dec;
  logic seq_skip;
  logic [FLAG1_W-1:0] set1;
  logic explicit;
  logic auto_trig;
  logic trig;
  logic flush;
  logic byte_in;
  logic fifo_ready;
  logic get_cmd;
  logic wr_flag0;
  logic wr_flag1;
  logic wr_opt_vol;
  logic [8:0] seq_next;
  efp_pkt_type pkt_in;

  // ==========================================
  // Event decode
  assign cmd_fall = st.cmd_s3 & ~st.cmd_s2;
  assign explicit = st.opt_vol[OPT_EXPLICIT];
  // Command line fall only counts when enabled
  assign send_now = cmd.send
    | (cmd_fall & st.opt_vol[OPT_CMD_SEND]);
  // Acked sends report only on the ack
  assign tx_done_set = (events.tx_sent & ~events.tx_ack_needed)
    | events.ack_rcvd;
  assign seq_next = {1'b0, st.prev_seq} + 9'h001;
  assign seq_dec = events.rx_enc_valid & st.seq_seen
    & (events.rx_seq < st.prev_seq);
  assign seq_skip = events.rx_enc_valid & st.seq_seen
    & ({1'b0, events.rx_seq} > seq_next);
  assign set1 = {events.join_start, seq_skip, seq_dec,
    events.rx_plain & accept_plaintext_option,
    1'b0, tx_done_set};
  assign wr_flag0 = reg_req.wr & (reg_req.addr == ADDR_FLAG0);
  assign wr_flag1 = reg_req.wr & (reg_req.addr == ADDR_FLAG1);
  assign wr_opt_vol = reg_req.wr & (reg_req.addr == ADDR_OPT_VOL);

  // ==========================================
  // Transmit grouping
  assign byte_in = tx_byte_valid & tx_byte_ready;
  // Counter saturation stalls the byte source
  assign tx_byte_ready = (st.pending != PENDING_MAX) & ~flush;
  assign auto_trig = ~explicit & (
    ((st.pending >= byte_count_trigger) && (byte_count_trigger != 8'h00))
    | (st.idle > data_idle_timeout)
    | (st.pending > slot_room));
  // Explicit mode relies on the send request alone
  assign trig = (st.send_req | auto_trig) & (st.pending != 8'h00)
    & fifo_ready & ~flush;
  // Changing grouping mode discards queued data
  assign flush = wr_opt_vol
    & (reg_req.wdata[OPT_EXPLICIT] != explicit);
  assign tx_flush = flush;
  // Length frozen at the trigger instant
  assign pkt_in.len = st.pending;

  efp_pair_buf #(
    .WIDTH($bits(efp_pkt_type))
  ) u_pkt_buf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .flush(flush),
    .in_valid(trig),
    .in_ready(fifo_ready),
    .in_data(pkt_in),
    .out_valid(pkt_valid),
    .out_ready(pkt_ready),
    .out_data(pkt)
  );

  // ==========================================
  // Receive delivery and status pins
  assign get_cmd = cmd.get_header | cmd.get_data | cmd.get_both;
  assign rx_xfer_active = st.rx_active;
  // Hold setting only matters when streaming
  assign rx_stream_enable = ~st.opt_vol[OPT_HELD_RX]
    & ~command_hold_setting;
  assign cts_status_drive = st.opt_vol[OPT_CTS_STATUS]
    & st.rx_active;
  assign cts_flow_enable = ~cts_status_drive;
  assign command_response_line_status_drive = ~st.opt_vol[OPT_CTS_STATUS]
    & st.rx_active;
  assign alert_status_line = st.alert;
  assign reg_rdata = st.rdata;
  assign packet_transfer_options = st.opt_vol;

  // ==========================================
  // Next state
  always_comb
  begin
    next_st = st;
    // Command pin synchroniser
    next_st.cmd_s1 = cmd_line_n;
    next_st.cmd_s2 = st.cmd_s1;
    next_st.cmd_s3 = st.cmd_s2;
    // Write ANDs so unread flags survive a clear
    if (wr_flag0)
    begin
      next_st.flags0 = st.flags0 & reg_req.wdata;
    end
    if (wr_flag1)
    begin
      next_st.flags1 = st.flags1 & reg_req.wdata[FLAG1_W-1:0];
    end
    // Sets applied last so they win over a clear
    next_st.flags0 = next_st.flags0 | events.lsb;
    next_st.flags1 = next_st.flags1 | set1;
    // Receive waiting is a live level, not sticky
    next_st.flags1[BIT_RX_WAIT] = rx_bytes_pending;
    if (events.rx_enc_valid)
    begin
      next_st.prev_seq = events.rx_seq;
      next_st.seq_seen = 1'b1;
    end
    // Option registers, reserved bits dropped
    if (wr_opt_vol)
    begin
      next_st.opt_vol = reg_req.wdata[OPT_W-1:0];
    end
    if (reg_req.wr && reg_req.addr == ADDR_OPT_NV)
    begin
      next_st.opt_nv = reg_req.wdata[OPT_W-1:0];
    end
    // Read mux, unmapped and reserved read zero
    if (reg_req.rd && reg_req.addr == ADDR_FLAG0)
    begin
      next_st.rdata = st.flags0;
    end
    else if (reg_req.rd && reg_req.addr == ADDR_FLAG1)
    begin
      next_st.rdata = {2'b00, st.flags1};
    end
    else if (reg_req.rd && reg_req.addr == ADDR_OPT_VOL)
    begin
      next_st.rdata = {4'h0, st.opt_vol};
    end
    else if (reg_req.rd && reg_req.addr == ADDR_OPT_NV)
    begin
      next_st.rdata = {4'h0, st.opt_nv};
    end
    else if (reg_req.rd)
    begin
      next_st.rdata = FLAG_RESET;
    end
    // Alert from next flags keeps it in step with them
    next_st.alert = (|({next_st.flags1, next_st.flags0}
      & extended_event_mask[13:0]))
      & (legacy_event_mask == 8'h00);
    // Pending byte count and idle timer
    if (flush)
    begin
      next_st.pending = 8'h00;
      next_st.send_req = 1'b0;
    end
    else if (trig)
    begin
      next_st.pending = {7'h00, byte_in};
      next_st.send_req = send_now;
    end
    else
    begin
      next_st.pending = st.pending + {7'h00, byte_in};
      next_st.send_req = (st.send_req | send_now)
        & ((st.pending != 8'h00) | byte_in);
    end
    if (byte_in || st.pending == 8'h00)
    begin
      next_st.idle = 16'h0000;
    end
    else if (st.idle != IDLE_MAX)
    begin
      next_st.idle = st.idle + 16'h0001;
    end
    // Held packets released by a get command
    if (rx_xfer_done)
    begin
      next_st.rx_active = 1'b0;
    end
    else if (get_cmd && st.opt_vol[OPT_HELD_RX])
    begin
      next_st.rx_active = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.opt_vol <= OPT_RESET;
      st.opt_nv <= OPT_RESET;
      st.cmd_s1 <= 1'b1;
      st.cmd_s2 <= 1'b1;
      st.cmd_s3 <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence seq_quiet0;
    events.lsb == 8'h00;
  endsequence

  sequence seq_cmd_fall;
    st.cmd_s3 && !st.cmd_s2;
  endsequence

  chk_flag_sticky: assert property (
    events.lsb[3] |=> st.flags0[3] && alert_status_line ==
      ((|({st.flags1, st.flags0} & $past(extended_event_mask[13:0])))
      && $past(legacy_event_mask) == 8'h00))
    else $error("event bit not kept");

  chk_alert_on: assert property (
    (events.lsb[0] && extended_event_mask[0]
      && legacy_event_mask == 8'h00) |=> alert_status_line)
    else $error("alert missing");

  chk_alert_off: assert property (
    legacy_event_mask != 8'h00 |=> !alert_status_line)
    else $error("alert with legacy mask set");

  chk_read_keeps: assert property (
    ((reg_req.rd && !wr_flag0 && reg_req.addr == ADDR_FLAG0) and seq_quiet0)
      |=> st.flags0 == $past(st.flags0)
      && reg_rdata == $past(st.flags0))
    else $error("read changed flags");

  chk_write_and: assert property (
    (wr_flag0 and seq_quiet0)
      |=> st.flags0 == ($past(st.flags0) & $past(reg_req.wdata)))
    else $error("flag write not AND");

  chk_never_set: assert property (
    (wr_flag1 && set1 == '0) |=> ((st.flags1
      & ~$past(st.flags1)) & ~(FLAG1_W'(1) << BIT_RX_WAIT)) == '0)
    else $error("host write set a flag");

  chk_set_wins: assert property (
    (wr_flag0 && events.lsb != 8'h00)
      |=> (st.flags0 & $past(events.lsb)) == $past(events.lsb))
    else $error("clear beat event");

  chk_ack_wait: assert property (
    (events.tx_sent && events.tx_ack_needed && !events.ack_rcvd
      && !st.flags1[BIT_TX_DONE] && !wr_flag1)
      |=> !st.flags1[BIT_TX_DONE])
    else $error("done before ack");

  chk_rx_wait: assert property (
    rx_bytes_pending |=> st.flags1[BIT_RX_WAIT] ##1
      st.flags1[BIT_RX_WAIT] == $past(rx_bytes_pending))
    else $error("receive waiting wrong");

  chk_opt_upper: assert property (
    (reg_req.rd && (reg_req.addr == ADDR_OPT_VOL
      || reg_req.addr == ADDR_OPT_NV)) |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved option bits");

  chk_explicit_hold: assert property (
    (explicit && !st.send_req) |-> !trig)
    else $error("explicit sent unasked");

  chk_cmd_send: assert property (
    (seq_cmd_fall and (st.opt_vol[OPT_CMD_SEND] && !flush
      && st.pending != 8'h00 && !trig)) |=> st.send_req)
    else $error("command fall ignored");

  chk_flush: assert property (
    flush |=> st.pending == 8'h00 && !pkt_valid)
    else $error("mode change kept data");

endmodule

// ### logic/efp_pair_buf.sv
`timescale 1ns/1ps
// ==========================================
// Two-entry buffer, full throughput
module efp_pair_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [WIDTH-1:0] d0;
    logic [WIDTH-1:0] d1;
    logic [1:0] count;
  } efp_buf_type;

  efp_buf_type st;
  efp_buf_type next_st;
  logic push;
  logic pop;

  // Head always in d0, so the output is straight from a flop
  assign in_ready = (st.count != 2'd2);
  assign out_valid = (st.count != 2'd0);
  assign out_data = st.d0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    next_st = st;
    if (pop)
    begin
      next_st.d0 = st.d1;
    end
    if (push)
    begin
      if (st.count == 2'd0 || (st.count == 2'd1 && pop))
      begin
        next_st.d0 = in_data;
      end
      else
      begin
        next_st.d1 = in_data;
      end
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
    // Flush drops everything queued, incoming word too
    if (flush)
    begin
      next_st.count = 2'd0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// ### logic/efp_pkg.sv
package efp_pkg;

  // ==========================================
  // Register offsets
  localparam logic [7:0] ADDR_OPT_NV = 8'h83;
  localparam logic [7:0] ADDR_FLAG2 = 8'hCD;
  localparam logic [7:0] ADDR_FLAG1 = 8'hCE;
  localparam logic [7:0] ADDR_FLAG0 = 8'hCF;
  localparam logic [7:0] ADDR_OPT_VOL = 8'hD3;

  // ==========================================
  // Field positions and reset values
  localparam int BIT_TX_DONE = 0;
  localparam int BIT_RX_WAIT = 1;
  localparam int BIT_PLAIN = 2;
  localparam int BIT_SEQ_DEC = 3;
  localparam int BIT_SEQ_SKIP = 4;
  localparam int BIT_JOIN = 5;
  localparam int OPT_EXPLICIT = 0;
  localparam int OPT_CMD_SEND = 1;
  localparam int OPT_HELD_RX = 2;
  localparam int OPT_CTS_STATUS = 3;
  localparam int FLAG1_W = 6;
  localparam int OPT_W = 4;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [3:0] OPT_RESET = 4'h0;
  localparam logic [7:0] PENDING_MAX = 8'hFF;
  localparam logic [15:0] IDLE_MAX = 16'hFFFF;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } efp_reg_req_type;

  typedef struct packed {
    logic tx_sent;
    logic tx_ack_needed;
    logic ack_rcvd;
    logic rx_plain;
    logic rx_enc_valid;
    logic [7:0] rx_seq;
    logic join_start;
    logic [7:0] lsb;
  } efp_event_type;

  typedef struct packed {
    logic send;
    logic get_header;
    logic get_data;
    logic get_both;
  } efp_cmd_type;

  typedef struct packed {
    logic [7:0] len;
  } efp_pkt_type;

endpackage

// ### testbench/efp_pkt_sink.sv
`timescale 1ns/1ps
// ==========================================
// Packet consumer on the descriptor side
module efp_pkt_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Descriptor handshake
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire efp_pkg::efp_pkt_type pkt,
  // Stall length and what was taken
  input wire logic [3:0] stall,
  output logic [7:0] last_len,
  output logic [7:0] got_count
);
  import efp_pkg::*;
  logic [3:0] wait_cnt;

  // Slow taker, so each packet waits in the two-entry queue for the stall
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_cnt <= 4'h0;
      last_len <= 8'h00;
      got_count <= 8'h00;
    end
    else if (pkt_valid && pkt_ready)
    begin
      last_len <= pkt.len;
      got_count <= got_count + 8'h01;
      wait_cnt <= 4'h0;
    end
    else if (pkt_valid)
      wait_cnt <= wait_cnt + 4'h1;
  end

  // Ready only after the stall has run out
  assign pkt_ready = pkt_valid && (wait_cnt >= stall);
endmodule

// ### testbench/test_efp_core.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the flag and packet option block
module test_efp_core;
  import efp_pkg::*;
  typedef struct packed {
    logic [7:0] lsb;
    logic [2:0] k;
    logic acc;
    logic [23:0] mask;
    logic [7:0] legacy;
    logic [7:0] addr;
    logic [7:0] exp;
    logic alert;
  } efp_row_type;
  logic clk_sys, arst_n, rx_bytes_pending, accept_plaintext_option;
  logic command_hold_setting, cmd_line_n, tx_byte_valid, tx_byte_ready;
  logic pkt_valid, pkt_ready, tx_flush, rx_xfer_done, rx_xfer_active;
  logic rx_stream_enable, cts_status_drive, cts_flow_enable;
  logic command_response_line_status_drive, alert_status_line;
  logic [7:0] reg_rdata, legacy_event_mask, byte_count_trigger, slot_room;
  logic [7:0] last_len, got_count, n0;
  logic [23:0] extended_event_mask;
  logic [15:0] data_idle_timeout;
  logic [3:0] packet_transfer_options, stall;
  efp_reg_req_type reg_req;
  efp_event_type events, ev;
  efp_cmd_type cmd;
  efp_pkt_type pkt;
  int bad_count, checked, cycles, flushes;
  efp_row_type rows [8] = '{
    '{8'h01, 3'h0, 1'b0, 24'h00_0001, 8'h00, ADDR_FLAG0, 8'h01, 1'b1},
    '{8'h80, 3'h0, 1'b0, 24'h00_0001, 8'h00, ADDR_FLAG0, 8'h80, 1'b0},
    '{8'h10, 3'h0, 1'b0, 24'h00_0010, 8'h01, ADDR_FLAG0, 8'h10, 1'b0},
    '{8'hFF, 3'h0, 1'b0, 24'h00_00FF, 8'h00, ADDR_FLAG0, 8'hFF, 1'b1},
    '{8'h00, 3'h1, 1'b0, 24'h00_0100, 8'h00, ADDR_FLAG1, 8'h01, 1'b1},
    '{8'h00, 3'h2, 1'b0, 24'h00_2000, 8'h00, ADDR_FLAG1, 8'h20, 1'b1},
    '{8'h00, 3'h4, 1'b1, 24'h00_0400, 8'h00, ADDR_FLAG1, 8'h04, 1'b1},
    '{8'h00, 3'h4, 1'b0, 24'h00_0400, 8'h00, ADDR_FLAG1, 8'h00, 1'b0}};

  efp_core u_efp_core (.clk_sys, .arst_n, .reg_req, .reg_rdata, .events,
    .rx_bytes_pending, .accept_plaintext_option, .extended_event_mask,
    .legacy_event_mask, .byte_count_trigger, .data_idle_timeout, .slot_room,
    .command_hold_setting, .cmd, .cmd_line_n, .tx_byte_valid, .tx_byte_ready,
    .pkt_valid, .pkt_ready, .pkt, .tx_flush, .rx_xfer_done, .rx_xfer_active,
    .rx_stream_enable, .cts_status_drive, .cts_flow_enable,
    .command_response_line_status_drive, .alert_status_line, .packet_transfer_options);
  efp_pkt_sink u_efp_pkt_sink (.clk_sys, .arst_n, .pkt_valid, .pkt_ready,
    .pkt, .stall, .last_len, .got_count);

  // ==========================================
  // Clock, flush watcher and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (tx_flush === 1'b1)
      flushes++;
    if (cycles == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ==========================================
  // Shared tasks; each enters and leaves 1 ns after an edge
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    step();
    reg_req = '0;
    step();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    step();
    reg_req = '0;
    check(reg_rdata, exp);
    step();
  endtask
  task automatic pulse(input efp_event_type e);
    events = e;
    step();
    events = '0;
    step();
  endtask
  task automatic bytes(input int n);
    int k;
    logic ok;
    k = 0;
    tx_byte_valid = 1'b1;
    while (k < n)
    begin
      ok = tx_byte_ready;
      step();
      if (ok)
        k++;
    end
    tx_byte_valid = 1'b0;
    step();
  endtask
  task automatic wait_pkt(input logic [7:0] len);
    for (int i = 0; i < 200 && got_count == n0; i++)
      step();
    check(got_count, n0 + 8'h01);
    check(last_len, len);
    n0 = got_count;
  endtask
  task automatic send_cmd(input efp_cmd_type c);
    cmd = c;
    step();
    cmd = '0;
  endtask
  function automatic efp_event_type ev_of(input logic [7:0] l,
    input logic [2:0] k);
    ev_of = '0;
    ev_of.lsb = l;
    ev_of.tx_sent = k[0];
    ev_of.join_start = k[1];
    ev_of.rx_plain = k[2];
  endfunction
  task automatic stop_test();
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    {reg_req, events, cmd, rx_bytes_pending, tx_byte_valid} = '0;
    {rx_xfer_done, accept_plaintext_option, command_hold_setting} = '0;
    {extended_event_mask, legacy_event_mask} = '0;
    {byte_count_trigger, n0} = '0;
    cmd_line_n = 1'b1;
    slot_room = 8'hFF;
    data_idle_timeout = 16'hFFFF;
    stall = 4'h4;
    arst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    step();
    // Ordinary flag cases: raise, read twice, clear
    foreach (rows[i])
    begin
      extended_event_mask = rows[i].mask;
      legacy_event_mask = rows[i].legacy;
      accept_plaintext_option = rows[i].acc;
      pulse(ev_of(rows[i].lsb, rows[i].k));
      check({7'h00, alert_status_line}, {7'h00, rows[i].alert});
      rd_chk(rows[i].addr, rows[i].exp);
      rd_chk(rows[i].addr, rows[i].exp);
      reg_wr(rows[i].addr, 8'h00);
      rd_chk(rows[i].addr, 8'h00);
      check({7'h00, alert_status_line}, 8'h00);
    end
    // AND write racing a fresh event
    pulse(ev_of(8'h03, 3'h0));
    events = ev_of(8'h08, 3'h0);
    reg_req = '{rd: 1'b0, wr: 1'b1, addr: ADDR_FLAG0, wdata: 8'hFD};
    step();
    {events, reg_req} = '0;
    step();
    rd_chk(ADDR_FLAG0, 8'h09);
    reg_wr(ADDR_FLAG0, 8'hFF);
    rd_chk(ADDR_FLAG0, 8'h09);
    reg_wr(ADDR_FLAG2, 8'hFF);
    rd_chk(ADDR_FLAG2, 8'h00);
    // Acknowledged send waits for the ack
    ev = ev_of(8'h00, 3'h1);
    ev.tx_ack_needed = 1'b1;
    pulse(ev);
    rd_chk(ADDR_FLAG1, 8'h00);
    ev = '0;
    ev.ack_rcvd = 1'b1;
    pulse(ev);
    rd_chk(ADDR_FLAG1, 8'h01);
    // Receive waiting follows the level, not host writes
    rx_bytes_pending = 1'b1;
    reg_wr(ADDR_FLAG1, 8'h00);
    rd_chk(ADDR_FLAG1, 8'h02);
    rx_bytes_pending = 1'b0;
    step();
    rd_chk(ADDR_FLAG1, 8'h00);
    // Sequence numbers 5, 4, 5, 7
    ev = '0;
    ev.rx_enc_valid = 1'b1;
    ev.rx_seq = 8'h05;
    pulse(ev);
    ev.rx_seq = 8'h04;
    pulse(ev);
    rd_chk(ADDR_FLAG1, 8'h08);
    reg_wr(ADDR_FLAG1, 8'h00);
    ev.rx_seq = 8'h05;
    pulse(ev);
    rd_chk(ADDR_FLAG1, 8'h00);
    ev.rx_seq = 8'h07;
    pulse(ev);
    rd_chk(ADDR_FLAG1, 8'h10);
    // Option registers and flush on explicit-mode change
    flushes = 0;
    reg_wr(ADDR_OPT_VOL, 8'hFF);
    rd_chk(ADDR_OPT_VOL, 8'h0F);
    check({4'h0, packet_transfer_options}, 8'h0F);
    reg_wr(ADDR_OPT_VOL, 8'h0F);
    check(8'(flushes), 8'h01);
    reg_wr(ADDR_OPT_NV, 8'hF5);
    rd_chk(ADDR_OPT_NV, 8'h05);
    // Explicit mode: triggers ignored, late byte goes to next packet
    reg_wr(ADDR_OPT_VOL, 8'h01);
    byte_count_trigger = 8'h02;
    data_idle_timeout = 16'h0008;
    bytes(3);
    repeat (30) step();
    check(got_count, n0);
    send_cmd(4'h8);
    tx_byte_valid = 1'b1;
    step();
    tx_byte_valid = 1'b0;
    wait_pkt(8'h03);
    send_cmd(4'h8);
    wait_pkt(8'h01);
    // Command pin fall acts as send
    reg_wr(ADDR_OPT_VOL, 8'h03);
    bytes(2);
    cmd_line_n = 1'b0;
    wait_pkt(8'h02);
    cmd_line_n = 1'b1;
    // Automatic mode: byte count, then idle timeout
    data_idle_timeout = 16'hFFFF;
    byte_count_trigger = 8'h04;
    reg_wr(ADDR_OPT_VOL, 8'h00);
    bytes(4);
    wait_pkt(8'h04);
    byte_count_trigger = 8'h00;
    data_idle_timeout = 16'h0010;
    bytes(2);
    wait_pkt(8'h02);
    // Slot room and a send command in automatic mode
    data_idle_timeout = 16'hFFFF;
    slot_room = 8'h02;
    bytes(3);
    wait_pkt(8'h03);
    slot_room = 8'hFF;
    bytes(1);
    send_cmd(4'h8);
    wait_pkt(8'h01);
    // Held receive with CTS status, all three get commands
    reg_wr(ADDR_OPT_VOL, 8'h0C);
    check({7'h00, rx_stream_enable}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      send_cmd(efp_cmd_type'(4'h4 >> i));
      check({7'h00, rx_xfer_active}, 8'h01);
      check({5'h00, command_response_line_status_drive, cts_status_drive,
        cts_flow_enable}, 8'h02);
      rx_xfer_done = 1'b1;
      step();
      rx_xfer_done = 1'b0;
      check({7'h00, rx_xfer_active}, 8'h00);
    end
    // Held receive without CTS option: status on response line
    reg_wr(ADDR_OPT_VOL, 8'h04);
    send_cmd(4'h1);
    check({5'h00, command_response_line_status_drive, cts_status_drive,
      cts_flow_enable}, 8'h05);
    rx_xfer_done = 1'b1;
    step();
    rx_xfer_done = 1'b0;
    reg_wr(ADDR_OPT_VOL, 8'h00);
    check({6'h00, command_response_line_status_drive, cts_flow_enable}, 8'h01);
    check({7'h00, rx_stream_enable}, 8'h01);
    command_hold_setting = 1'b1;
    step();
    check({7'h00, rx_stream_enable}, 8'h00);
    command_hold_setting = 1'b0;
    // Second reset in mid-run clears flags and options
    reg_wr(ADDR_OPT_VOL, 8'h0E);
    pulse(ev_of(8'hFF, 3'h0));
    arst_n = 1'b0;
    step();
    arst_n = 1'b1;
    step();
    rd_chk(ADDR_FLAG0, 8'h00);
    rd_chk(ADDR_OPT_VOL, 8'h00);
    check({7'h00, alert_status_line}, 8'h00);
    stop_test();
  end
endmodule
